// ---- rtl/afic_top.v ----
// filter selection decode, interface config register and crc checks behind apb
//
// Contract
// RULE1 - codes 10100..11011: sinc4 ratio 32 then sinc1 ratio 4,10,20,40,100,200,400,1000.
// RULE2 - code 11100: sinc3 ratio 26667; code 11101: sinc3 ratio 32000.
// RULE3 - codes 11110, 11111: sinc3 ratio 32000 then sinc1 ratio 3 or 5.
// RULE4 - interface config at address 8, resets to 08h, reserved bit 3 reads one.
// RULE5 - bit 7 picks clock source: 0 internal oscillator, 1 external clock.
// RULE6 - bit 6 set divides the external clock by eight, clear passes it.
// RULE7 - bit 5: 0 full drive, 1 half drive on digital outputs.
// RULE8 - bit 4: 0 bipolar two's complement, 1 unipolar straight binary.
// RULE9 - bit 2 enables input frame crc check and output frame crc byte.
// RULE10 - input crc mismatch sets link error flag; host clears it writing one.
// RULE11 - bit 1: host writes crc of regs 0-1, 4-E into Fh; device compares.
// RULE12 - while check enabled, register error flag set when internal crc differs.
// RULE13 - bit 0 set puts status byte ahead of conversion data; clear omits it.
// RULE14 - with check disabled, register Fh is plain scratch, no flag effect.
// RULE15 - comparison re-run after each write to a covered register or Fh.
//
// Implementation choice: the APB interface to the registers.
`include "afic_defines.vh"
`default_nettype none
module afic_top (
	input  wire        clk_sys_i,      // 200 MHz system clock
	input  wire        nrst_i,         // async reset, active low
	input  wire        psel_i,         // apb select
	input  wire        penable_i,      // apb enable
	input  wire        pwrite_i,       // apb direction
	input  wire [31:0] paddr_i,        // apb byte address
	input  wire [31:0] pwdata_i,       // apb write data
	input  wire [3:0]  pstrb_i,        // apb byte strobes
	output reg         pready_o,       // apb ready
	output reg  [31:0] prdata_o,       // apb read data
	output reg         pslverr_o,      // apb error, unmapped address
	input  wire        ext_clk_i,      // external conversion clock pin
	input  wire        int_osc_tick_i, // internal oscillator tick, same domain
	input  wire        frame_crc_err_i,// serial input frame crc mismatch pulse
	output reg         conv_tick_o,    // conversion clock tick
	output reg         drive_half_o,   // digital outputs at half drive
	output reg         unipolar_o,     // unipolar range, straight binary
	output reg         spi_crc_en_o,   // frame crc check and append enabled
	output reg         status_pre_o,   // status byte prefixed to data
	output reg  [7:0]  status_byte_o,  // current status byte
	output reg         filt_valid_o,   // filter code among decoded ones
	output reg  [1:0]  filt_type_o,    // decoded filter type
	output reg  [15:0] osr_main_o,     // oversampling_ratio of first stage
	output reg  [9:0]  osr_post_o      // oversampling_ratio of sinc1 stage
);
	// crc walk covers registers 0-1 and 4-e
	function covered;
		input [3:0] idx;
		begin
			covered = (idx <= `AFIC_IDX_CRC_LAST) && (idx != 4'h2) && (idx != 4'h3);
		end
	endfunction

	reg        rst_meta_q;
	reg        rst_sync_q;
	wire       rst_n;

	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	// storage for registers without own logic here, used for crc coverage
	reg  [7:0] mem_q [0:15];
	reg  [7:0] ifcfg_q;
	reg        spi_err_q;
	reg        reg_err_q;

	wire [3:0] idx        = paddr_i[5:2];
	wire       mapped     = (paddr_i[31:6] == 26'h0) && (paddr_i[1:0] == 2'h0);
	wire       acc        = psel_i && penable_i && pready_o;
	wire       wr_ok      = acc && pwrite_i && mapped && pstrb_i[0];
	wire [7:0] wbyte      = pwdata_i[7:0];
	wire [7:0] ifcfg_rd   = ifcfg_q | `AFIC_IFCFG_RESET; // RULE4
	wire [7:0] status_rd  = {6'h00, spi_err_q, reg_err_q};

	wire       clk_sel    = ifcfg_q[`AFIC_BIT_CLK_SEL];
	wire       clk_div    = ifcfg_q[`AFIC_BIT_CLK_DIV];
	wire       spi_crc_en = ifcfg_q[`AFIC_BIT_SPI_CRC];
	wire       reg_crc_en = ifcfg_q[`AFIC_BIT_REG_CRC];

	reg  [7:0] rd_byte;
	always @* begin
		case (idx)
			`AFIC_IDX_STATUS: rd_byte = status_rd;
			`AFIC_IDX_IFCFG:  rd_byte = ifcfg_rd;
			default:          rd_byte = mem_q[idx];
		endcase
	end

	// apb: ready raised for the access phase, one wait-free answer
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !mapped;
			if (psel_i && !penable_i) begin
				prdata_o <= (mapped && !pwrite_i) ? {24'h000000, rd_byte} : 32'h0000_0000;
			end
		end
	end

	integer k;
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			for (k = 0; k < 16; k = k + 1) begin
				mem_q[k] <= 8'h00;
			end
			ifcfg_q <= `AFIC_IFCFG_RESET; // RULE4
		end else if (wr_ok) begin
			case (idx)
				`AFIC_IDX_STATUS: ;
				`AFIC_IDX_IFCFG:  ifcfg_q <= (wbyte & `AFIC_IFCFG_WMASK) | `AFIC_IFCFG_RESET; // RULE4
				default:          mem_q[idx] <= wbyte; // RULE14
			endcase
		end
	end

	// link error: set wins over the write-one clear
	wire spi_err_clr = wr_ok && (idx == `AFIC_IDX_STATUS) && wbyte[`AFIC_BIT_SPI_ERR];
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			spi_err_q <= 1'b0;
		end else if (spi_crc_en && frame_crc_err_i) begin
			spi_err_q <= 1'b1; // RULE10
		end else if (spi_err_clr) begin
			spi_err_q <= 1'b0; // RULE10
		end
	end

	// register map crc walk, restarted by any relevant write
	reg  [3:0] walk_idx_q;
	reg        walk_busy_q;
	reg  [7:0] crc_acc_q;
	wire [7:0] crc_next;
	wire [7:0] walk_byte = (walk_idx_q == `AFIC_IDX_IFCFG) ? ifcfg_rd : mem_q[walk_idx_q];
	wire       rerun     = (wr_ok && (covered(idx) || idx == `AFIC_IDX_REGCRC)) ||
	                       (wr_ok && idx == `AFIC_IDX_IFCFG); // RULE15
	reg        en_prev_q;

	afic_crc8 #(
		.POLY(`AFIC_CRC_POLY)
	) u_crc (
		.crc_i  (crc_acc_q),
		.data_i (walk_byte),
		.crc_o  (crc_next)
	);

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			walk_idx_q  <= `AFIC_IDX_CRC_FIRST;
			walk_busy_q <= 1'b0;
			crc_acc_q   <= 8'h00;
			reg_err_q   <= 1'b0;
			en_prev_q   <= 1'b0;
		end else begin
			en_prev_q <= reg_crc_en;
			if (rerun || (reg_crc_en && !en_prev_q)) begin
				walk_idx_q  <= `AFIC_IDX_CRC_FIRST; // RULE15
				walk_busy_q <= 1'b1;
				crc_acc_q   <= 8'h00;
			end else if (walk_busy_q) begin
				if (covered(walk_idx_q)) begin
					crc_acc_q <= crc_next; // RULE11
				end
				if (walk_idx_q == `AFIC_IDX_CRC_LAST) begin
					walk_busy_q <= 1'b0;
				end else begin
					walk_idx_q <= walk_idx_q + 4'h1;
				end
			end
			if (!reg_crc_en) begin
				reg_err_q <= 1'b0; // RULE14
			end else if (walk_busy_q && !rerun && walk_idx_q == `AFIC_IDX_CRC_LAST) begin
				reg_err_q <= (crc_next != mem_q[`AFIC_IDX_REGCRC]); // RULE12
			end
		end
	end

	// conversion clock: external pin synchronised, optionally divided by eight
	reg        ext_meta_q;
	reg        ext_sync_q;
	reg        ext_prev_q;
	reg  [3:0] div_cnt_q;
	wire       ext_rise = ext_sync_q && !ext_prev_q;

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
			div_cnt_q  <= 4'h0;
		end else begin
			ext_meta_q <= ext_clk_i;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_sync_q;
			if (!clk_div) begin
				div_cnt_q <= 4'h0;
			end else if (ext_rise) begin
				div_cnt_q <= (div_cnt_q == `AFIC_EXT_DIV - 4'h1) ? 4'h0 : div_cnt_q + 4'h1; // RULE6
			end
		end
	end

	wire ext_tick = ext_rise && (!clk_div || div_cnt_q == `AFIC_EXT_DIV - 4'h1); // RULE6

	wire        dec_valid;
	wire [1:0]  dec_type;
	wire [15:0] dec_main;
	wire [9:0]  dec_post;

	afic_filter_decode u_dec (
		.code_i     (mem_q[`AFIC_IDX_FILTER][4:0]),
		.valid_o    (dec_valid),
		.ftype_o    (dec_type),
		.osr_main_o (dec_main),
		.osr_post_o (dec_post)
	);

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			conv_tick_o   <= 1'b0;
			drive_half_o  <= 1'b0;
			unipolar_o    <= 1'b0;
			spi_crc_en_o  <= 1'b0;
			status_pre_o  <= 1'b0;
			status_byte_o <= 8'h00;
			filt_valid_o  <= 1'b0;
			filt_type_o   <= `AFIC_FT_NONE;
			osr_main_o    <= 16'h0000;
			osr_post_o    <= 10'h000;
		end else begin
			conv_tick_o   <= clk_sel ? ext_tick : int_osc_tick_i; // RULE5
			drive_half_o  <= ifcfg_q[`AFIC_BIT_DRV_HALF]; // RULE7
			unipolar_o    <= ifcfg_q[`AFIC_BIT_UNIPOLAR]; // RULE8
			spi_crc_en_o  <= spi_crc_en; // RULE9
			status_pre_o  <= ifcfg_q[`AFIC_BIT_STAT_EN]; // RULE13
			status_byte_o <= status_rd;
			filt_valid_o  <= dec_valid;
			filt_type_o   <= dec_type; // RULE1
			osr_main_o    <= dec_main; // RULE2
			osr_post_o    <= dec_post; // RULE3
		end
	end
endmodule // afic_top
`default_nettype wire

// ---- rtl/afic_defines.vh ----
// register map, field positions and reset values of the filter and interface config block
`ifndef AFIC_DEFINES_VH
`define AFIC_DEFINES_VH

`define AFIC_IDX_W          4
`define AFIC_IDX_STATUS     4'h2
`define AFIC_IDX_FILTER     4'h3
`define AFIC_IDX_IFCFG      4'h8
`define AFIC_IDX_REGCRC     4'hf
`define AFIC_IDX_CRC_FIRST  4'h0
`define AFIC_IDX_CRC_LAST   4'he

`define AFIC_IFCFG_RESET    8'h08
`define AFIC_IFCFG_WMASK    8'hf7
`define AFIC_BIT_CLK_SEL    7
`define AFIC_BIT_CLK_DIV    6
`define AFIC_BIT_DRV_HALF   5
`define AFIC_BIT_UNIPOLAR   4
`define AFIC_BIT_SPI_CRC    2
`define AFIC_BIT_REG_CRC    1
`define AFIC_BIT_STAT_EN    0

`define AFIC_BIT_SPI_ERR    1
`define AFIC_BIT_REG_ERR    0

`define AFIC_EXT_DIV        4'h8
`define AFIC_CRC_POLY       8'h07

`define AFIC_FT_NONE        2'h0
`define AFIC_FT_S4_S1       2'h1
`define AFIC_FT_S3          2'h2
`define AFIC_FT_S3_S1       2'h3

`endif

// ---- rtl/afic_crc8.v ----
// one-byte update step of the register map crc
`include "afic_defines.vh"
`default_nettype none
module afic_crc8 #(
	parameter [7:0] POLY = `AFIC_CRC_POLY
) (
	input  wire [7:0] crc_i,   // running crc
	input  wire [7:0] data_i,  // byte to fold in
	output reg  [7:0] crc_o    // updated crc
);
	integer i;
	always @* begin
		crc_o = crc_i ^ data_i;
		for (i = 0; i < 8; i = i + 1) begin
			crc_o = crc_o[7] ? ({crc_o[6:0], 1'b0} ^ POLY) : {crc_o[6:0], 1'b0};
		end
	end
endmodule // afic_crc8
`default_nettype wire

// ---- rtl/afic_filter_decode.v ----
// decode of the upper filter selection codes into filter type and ratios
`include "afic_defines.vh"
`default_nettype none
module afic_filter_decode (
	input  wire [4:0]  code_i,     // filter selection code
	output reg         valid_o,    // code is one of the decoded ones
	output reg  [1:0]  ftype_o,    // filter type
	output reg  [15:0] osr_main_o, // ratio of the higher-order stage
	output reg  [9:0]  osr_post_o  // ratio of the first-order stage, 0 if none
);
	always @* begin
		valid_o    = 1'b1;
		ftype_o    = `AFIC_FT_S4_S1;
		osr_main_o = 16'h0020;
		osr_post_o = 10'h000;
		case (code_i)
			5'h14: osr_post_o = 10'h004; // RULE1
			5'h15: osr_post_o = 10'h00a; // RULE1
			5'h16: osr_post_o = 10'h014; // RULE1
			5'h17: osr_post_o = 10'h028; // RULE1
			5'h18: osr_post_o = 10'h064; // RULE1
			5'h19: osr_post_o = 10'h0c8; // RULE1
			5'h1a: osr_post_o = 10'h190; // RULE1
			5'h1b: osr_post_o = 10'h3e8; // RULE1
			5'h1c: begin
				ftype_o    = `AFIC_FT_S3; // RULE2
				osr_main_o = 16'h682b;
			end
			5'h1d: begin
				ftype_o    = `AFIC_FT_S3; // RULE2
				osr_main_o = 16'h7d00;
			end
			5'h1e: begin
				ftype_o    = `AFIC_FT_S3_S1; // RULE3
				osr_main_o = 16'h7d00;
				osr_post_o = 10'h003;
			end
			5'h1f: begin
				ftype_o    = `AFIC_FT_S3_S1; // RULE3
				osr_main_o = 16'h7d00;
				osr_post_o = 10'h005;
			end
			default: begin
				// lower codes are decoded elsewhere
				valid_o    = 1'b0;
				ftype_o    = `AFIC_FT_NONE;
				osr_main_o = 16'h0000;
			end
		endcase
	end
endmodule // afic_filter_decode
`default_nettype wire

// ---- tb/afic_top_sva.sv ----
// port-level assertions for the filter and interface config block
`include "afic_defines.vh"
`default_nettype none
module afic_top_sva (
	input wire logic        clk_sys_i,
	input wire logic        nrst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic        pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	input wire logic        frame_crc_err_i,
	input wire logic        drive_half_o,
	input wire logic        unipolar_o,
	input wire logic        spi_crc_en_o,
	input wire logic        status_pre_o,
	input wire logic [7:0]  status_byte_o,
	input wire logic [1:0]  filt_type_o,
	input wire logic [15:0] osr_main_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	wire setup = psel_i & ~penable_i;
	wire wr_acc = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
	chk_rdy_setup: assert property (setup |=> pready_o)
		else $error("no ready after setup");
	chk_rdy_once: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	chk_rd_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_unmapped_err: assert property (setup && (paddr_i[31:6] != 0 || paddr_i[1:0] != 0)
		|=> pslverr_o && pready_o)
		else $error("unmapped access without error");
	chk_resv_one: assert property (setup && !pwrite_i && paddr_i == 32'h20 |=> prdata_o[3])
		else $error("reserved bit not one");
	chk_cfg_pins: assert property (wr_acc && paddr_i == 32'h20 |=> ##1
		{drive_half_o, unipolar_o, spi_crc_en_o, status_pre_o} == {$past(pwdata_i[5], 2),
		$past(pwdata_i[4], 2), $past(pwdata_i[2], 2), $past(pwdata_i[0], 2)})
		else $error("config outputs differ from written bits");
	chk_link_set: assert property (spi_crc_en_o && frame_crc_err_i && !$past(psel_i)
		|-> ##[1:2] status_byte_o[1])
		else $error("link error flag not set");
	chk_link_gate: assert property (!spi_crc_en_o && !$past(psel_i) && !psel_i
		&& !status_byte_o[1] |=> !status_byte_o[1] ##1 !status_byte_o[1])
		else $error("link error flag set while check off");
	chk_s4_main: assert property (filt_type_o == `AFIC_FT_S4_S1 |-> osr_main_o == 16'h0020)
		else $error("sinc4 stage ratio wrong");
	chk_s3_main: assert property (filt_type_o == `AFIC_FT_S3
		|-> osr_main_o == 16'h682b || osr_main_o == 16'h7d00)
		else $error("sinc3 ratio wrong");
	chk_s3s1_main: assert property (filt_type_o == `AFIC_FT_S3_S1 |-> osr_main_o == 16'h7d00)
		else $error("sinc3 stage ratio wrong");
	cover property (wr_acc && paddr_i == 32'h20);
	cover property (frame_crc_err_i && spi_crc_en_o);
	cover property (pslverr_o);
	cover property (status_byte_o[0]);
endmodule // afic_top_sva
bind afic_top afic_top_sva u_sva (.*);
`default_nettype wire

// ---- tb/afic_top_tb.sv ----
// self-checking bench for the filter and interface config block
`include "afic_defines.vh"
`default_nettype none
module afic_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic ext_clk_i = 0, int_osc_tick_i = 0, frame_crc_err_i = 0;
	logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, rv;
	logic [3:0]  pstrb_i = 0;
	logic pready_o, pslverr_o, conv_tick_o, drive_half_o, unipolar_o, re;
	logic spi_crc_en_o, status_pre_o, filt_valid_o;
	logic [7:0]  status_byte_o;
	logic [1:0]  filt_type_o;
	logic [15:0] osr_main_o;
	logic [9:0]  osr_post_o;
	int n_errors = 0, checks_done = 0, nt = 0;
	afic_top dut (.*);
	always #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (conv_tick_o === 1'b1) nt <= nt + 1;
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
		@(posedge clk_sys_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} <= {2'b10, w, a, d, s};
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		// the bench watchdog, not a cycle count, ends a stuck wait
		do begin
			@(posedge clk_sys_i);
		end while (pready_o !== 1'b1);
		rv = prdata_o;
		re = pslverr_o;
		{psel_i, penable_i} <= 2'b00;
	endtask
	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d, 4'hf);
	endtask
	task automatic rd(input string nm, input logic [31:0] a, e);
		apb(1'b0, a, 32'h0, 4'hf);
		chk(nm, rv, e);
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, d);
		c = c ^ d;
		for (int k = 0; k < 8; k++)
			c = c[7] ? (c << 1) ^ `AFIC_CRC_POLY : c << 1;
		return c;
	endfunction
	task automatic t_cfg;
		rd("cfg rst", 32'h20, 32'h08);
		rd("crc rst", 32'h3c, 32'h0);
		wr(32'h20, 32'hff);
		rd("cfg all", 32'h20, 32'hff);
		chk("pins", {drive_half_o, unipolar_o, spi_crc_en_o, status_pre_o}, 32'hf);
		apb(1'b1, 32'h20, 32'h0, 4'h0);
		rd("cfg nostrb", 32'h20, 32'hff);
		wr(32'h20, 32'h0);
		rd("cfg clr", 32'h20, 32'h08);
		chk("pins off", {drive_half_o, unipolar_o, spi_crc_en_o, status_pre_o}, 32'h0);
		$display("t_cfg done");
	endtask
	task automatic t_filter;
		logic [9:0] post [12] = '{10'h004, 10'h00a, 10'h014, 10'h028, 10'h064, 10'h0c8,
			10'h190, 10'h3e8, 10'h000, 10'h000, 10'h003, 10'h005};
		logic [15:0] m;
		logic [1:0] t;
		for (int i = 0; i < 12; i++) begin
			wr(32'h0c, 32'h14 + i);
			repeat (2) @(posedge clk_sys_i);
			m = i < 8 ? 16'h0020 : i == 8 ? 16'h682b : 16'h7d00;
			t = i < 8 ? `AFIC_FT_S4_S1 : i < 10 ? `AFIC_FT_S3 : `AFIC_FT_S3_S1;
			chk("ftype", filt_type_o, t);
			chk("osr main", osr_main_o, m);
			chk("osr post", osr_post_o, post[i]);
			chk("fvalid", filt_valid_o, 32'h1);
		end
		wr(32'h0c, 32'h13);
		repeat (2) @(posedge clk_sys_i);
		chk("fvalid low", filt_valid_o, 32'h0);
		$display("t_filter done");
	endtask
	// both sources tick 16 times, so only the divided run shows a wrong selection as a wrong count
	task automatic ext(input string nm, input logic [7:0] c, input int e);
		int n0;
		wr(32'h20, c);
		n0 = nt;
		repeat (16) begin
			@(posedge clk_sys_i) {ext_clk_i, int_osc_tick_i} <= 2'b11;
			@(posedge clk_sys_i) int_osc_tick_i <= 1'b0;
			repeat (3) @(posedge clk_sys_i);
			ext_clk_i <= 1'b0;
			repeat (4) @(posedge clk_sys_i);
		end
		repeat (8) @(posedge clk_sys_i);
		chk(nm, nt - n0, e);
	endtask
	task automatic err_pulse;
		@(posedge clk_sys_i) frame_crc_err_i <= 1'b1;
		@(posedge clk_sys_i) frame_crc_err_i <= 1'b0;
	endtask
	task automatic t_link;
		ext("int ticks", 8'h00, 16);
		ext("ext ticks", 8'h80, 16);
		ext("div8 ticks", 8'hc0, 2);
		wr(32'h20, 32'h0);
		err_pulse();
		rd("link off", 32'h08, 32'h0);
		wr(32'h20, 32'h04);
		err_pulse();
		rd("link on", 32'h08, 32'h02);
		chk("status pin", status_byte_o, 32'h02);
		wr(32'h08, 32'h02);
		rd("link clr", 32'h08, 32'h0);
		$display("t_link done");
	endtask
	task automatic t_regcrc;
		logic [7:0] c;
		c = 8'h0;
		for (int i = 0; i < 15; i++)
			if (i != 2 && i != 3) c = crc8(c, i == 8 ? 8'h0a : 8'h00);
		wr(32'h20, 32'h02);
		wr(32'h3c, c);
		repeat (40) @(posedge clk_sys_i);
		rd("crc ok", 32'h08, 32'h0);
		wr(32'h3c, c ^ 8'h01);
		repeat (40) @(posedge clk_sys_i);
		rd("crc bad", 32'h08, 32'h01);
		wr(32'h20, 32'h0);
		repeat (40) @(posedge clk_sys_i);
		rd("crc off", 32'h08, 32'h0);
		rd("scratch", 32'h3c, c ^ 8'h01);
		rd("unmapped", 32'h40, 32'h0);
		chk("slverr", re, 32'h1);
		$display("t_regcrc done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		t_cfg();
		t_filter();
		t_link();
		t_regcrc();
		tally_and_finish();
	end
	initial begin
		#100000;
		n_errors++;
		tally_and_finish();
	end
endmodule // afic_top_tb
`default_nettype wire
